/* hw/status_consts.vh */
`ifndef STATUS_CONSTS_VH
`define STATUS_CONSTS_VH

// Width of every operation and questionable register.
`define REG_WIDTH            16
// Number of questionable detail register sets.
`define DETAIL_COUNT         6
// Integrity detail set index and its bit positions.
`define INTEGRITY_INDEX      3
`define AUTO_TRIG_TIMEOUT_BIT 10
`define INTEGRITY_SUM_BIT    9
// Status byte bit positions.
`define STB_ERROR_QUEUE_BIT  2
`define STB_QUES_BIT         3
`define STB_DATA_READY_BIT   4
`define STB_STD_EVENT_BIT    5
`define STB_MASTER_BIT       6
`define STB_OPER_BIT         7
// Operation bit that never reports status.
`define OPER_UNUSED_BIT      15
// Reset values of the filter and enable registers.
`define RISE_FILTER_RESET    16'hFFFF
`define FALL_FILTER_RESET    16'h0000
`define ENABLE_RESET         16'h0000
`define INTEGRITY_ENABLE_RESET 16'hFFFF
`define SRQ_ENABLE_RESET     8'h00
`define STD_ENABLE_RESET     8'h00
// Operation-complete query answer value.
`define OPC_ANSWER           8'h01

`endif

/* hw/sync_bits.v */
// Two flip-flop synchroniser for a bundle of independent level signals.
module sync_bits #(
  parameter WIDTH = 16
) (
  // Clock and reset.
  input  wire             clock,
  input  wire             rst,
  // Data.
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage_one;

  // The first stage is read only by the second stage.
  always @(posedge clock) begin
    if (rst) begin
      stage_one <= {WIDTH{1'b0}};
      sync_out  <= {WIDTH{1'b0}};
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end

endmodule // sync_bits

/* hw/status_reg_set.v */
`include "status_consts.vh"

// One register set: condition, two transition filters, sticky event,
// event enable and a registered summary.
module status_reg_set #(
  parameter WIDTH       = 16,
  parameter ENABLE_INIT = 16'h0000,
  parameter UNUSED_MASK = 16'h0000
) (
  // Clock and reset.
  input  wire             clock,
  input  wire             rst,
  // Live conditions, already on this clock.
  input  wire [WIDTH-1:0] cond_in,
  // Software writes, one-cycle strobes.
  input  wire             wr_rise,
  input  wire             wr_fall,
  input  wire             wr_enable,
  input  wire [WIDTH-1:0] wr_data,
  // Event read, global clear and preset.
  input  wire             rd_event,
  input  wire             clear_all,
  input  wire             preset,
  // Visible state.
  output wire [WIDTH-1:0] condition,
  output reg  [WIDTH-1:0] rise_filter,
  output reg  [WIDTH-1:0] fall_filter,
  output reg  [WIDTH-1:0] enable,
  output reg  [WIDTH-1:0] event_bits,
  output reg  [WIDTH-1:0] event_read,
  output reg              summary
);

  reg  [WIDTH-1:0] cond_prev;
  wire [WIDTH-1:0] set_bits;
  wire [WIDTH-1:0] next_event;

  // Condition is the live input with unused bits forced low.
  assign condition = cond_in & ~UNUSED_MASK;

  // Edges gated by the filters; both filters clear means never set.
  assign set_bits = (condition & ~cond_prev & rise_filter)
                  | (~condition & cond_prev & fall_filter);

  // A new event in the clearing cycle survives the clear.
  assign next_event = ((rd_event | clear_all) ? {WIDTH{1'b0}} : event_bits)
                    | set_bits;

  // Filter writes are bit weighted, stored verbatim; enable writes drop the unused bits.
  always @(posedge clock) begin
    if (rst) begin
      rise_filter <= `RISE_FILTER_RESET;
      fall_filter <= `FALL_FILTER_RESET;
      enable      <= ENABLE_INIT;
      cond_prev   <= {WIDTH{1'b0}};
      event_bits  <= {WIDTH{1'b0}};
      event_read  <= {WIDTH{1'b0}};
      summary     <= 1'b0;
    end else begin
      if (wr_rise)
        rise_filter <= wr_data;
      if (wr_fall)
        fall_filter <= wr_data;
      if (wr_enable)
        enable <= wr_data & ~UNUSED_MASK;
      // Preset restores the power-up filters and mask; the sticky events
      // are cleared through clear_all in the same cycle.
      if (preset) begin
        rise_filter <= `RISE_FILTER_RESET;
        fall_filter <= `FALL_FILTER_RESET;
        enable      <= ENABLE_INIT;
      end
      cond_prev  <= condition;
      event_bits <= next_event & ~UNUSED_MASK;
      if (rd_event)
        event_read <= event_bits;
      summary <= |(event_bits & enable & ~UNUSED_MASK);
    end
  end

endmodule // status_reg_set

/* hw/status_register_hierarchy.v */
`include "status_consts.vh"

// Notes on behaviour
// - Condition bits mirror live inputs each cycle.
// - Rising edge with rise filter sets event.
// - Falling edge with fall filter sets event.
// - Event bits stay set until cleared.
// - Event read, clear-status, preset clear events.
// - Summary is OR of enabled event bits.
// - Detail summaries feed questionable; it feeds byte.
// - Questionable summary at status byte bit three.
// - Operation set has only live inputs.
// - Preset: rise filters ones, fall filters zeros.
// - Both filters zero never sets event.
// - Auto-trigger timeout bit 10 feeds bit 9.
// - Integrity detail enable defaults all ones.
// - Operation bit 15 always zero.
// - Writes store bit-weighted values exactly, except masked unused bits and request enable bit 6.
// - Clear-status empties error queue, clears events.
// - Standard event read clears; status read does not.
// - Completion query waits idle, answers one.
// - Power-on clear flag clears two enables.
// - Status accesses run strictly in order.
// - Status byte bit layout as documented.
// - Request-service set on rise, poll clears.
// - Service request enable clears to zero at power-on clear.
module status_register_hierarchy #(
  parameter WIDTH   = `REG_WIDTH,
  parameter DETAILS = `DETAIL_COUNT
) (
  // Clock and reset; power_on marks a power-up reset.
  input  wire                     clock,
  input  wire                     rst,
  input  wire                     power_on,
  // Live instrument conditions from pins.
  input  wire [WIDTH-1:0]         oper_cond_pin,
  input  wire [DETAILS*WIDTH-1:0] detail_cond_pin,
  input  wire [WIDTH-1:0]         ques_cond_pin,
  input  wire                     auto_trig_timeout_pin,
  // Neighbouring status sources on this clock.
  input  wire                     error_queue_not_empty,
  input  wire                     output_data_ready,
  input  wire                     std_event_summary,
  input  wire                     ops_pending,
  // Command port: one-cycle strobe with register select and data.
  input  wire                     cmd_valid,
  input  wire [3:0]               cmd_code,
  input  wire [3:0]               cmd_set,
  input  wire [WIDTH-1:0]         cmd_data,
  input  wire                     psc_value,
  // Command handshake and answer.
  output wire                     cmd_ready,
  output reg                      resp_valid,
  output reg  [WIDTH-1:0]         resp_data,
  // Status outputs.
  output reg  [7:0]               status_byte,
  output reg  [7:0]               srq_enable,
  output reg  [7:0]               std_enable,
  output reg                      power_on_clear,
  output reg                      request_service_bit,
  output wire                     master_summary_bit,
  output reg                      clear_error_queue
);

  ////////////////////////////////////////////////////////////////////////
  // Command codes, set selects and states.
  // Codes outside this list are taken and answered with zero.
  localparam [3:0] CMD_RD_COND   = 4'h0;
  localparam [3:0] CMD_RD_EVENT  = 4'h1;
  localparam [3:0] CMD_WR_RISE   = 4'h2;
  localparam [3:0] CMD_WR_FALL   = 4'h3;
  localparam [3:0] CMD_WR_ENABLE = 4'h4;
  localparam [3:0] CMD_CLS       = 4'h5;
  localparam [3:0] CMD_RD_STB    = 4'h6;
  localparam [3:0] CMD_POLL      = 4'h7;
  localparam [3:0] CMD_WR_SRE    = 4'h8;
  localparam [3:0] CMD_WR_ESE    = 4'h9;
  localparam [3:0] CMD_OPC_Q     = 4'hA;
  localparam [3:0] CMD_WR_PSC    = 4'hB;
  localparam [3:0] CMD_PRESET    = 4'hC;
  // Selects of the operation and top questionable sets.
  localparam [3:0] SET_OPER      = 4'h6;
  localparam [3:0] SET_QUES      = 4'h7;
  // Sequencer states.
  localparam [1:0] ST_IDLE       = 2'd0;
  localparam [1:0] ST_EXEC       = 2'd1;
  localparam [1:0] ST_WAIT_OPC   = 2'd2;
  localparam [1:0] ST_ANSWER     = 2'd3;
  // Details first, then the operation set, then the top questionable set.
  localparam NSETS = DETAILS + 2;

  ////////////////////////////////////////////////////////////////////////
  // Synchronised pins.
  // Each bit is synchronised on its own, so a change on several pins in
  // one cycle may land over two cycles; the event logic sees that as two
  // separate transitions, which is harmless for sticky event bits.
  wire [WIDTH-1:0]         oper_cond;
  wire [DETAILS*WIDTH-1:0] detail_cond_s;
  wire [WIDTH-1:0]         ques_cond_s;
  wire                     timeout_s;

  // Operation pins.
  sync_bits #(.WIDTH(WIDTH)) u_sync_oper (
    .clock    (clock),
    .rst      (rst),
    .async_in (oper_cond_pin),
    .sync_out (oper_cond)
  );

  // Detail, questionable and timeout pins share one synchroniser.
  sync_bits #(.WIDTH(DETAILS*WIDTH+WIDTH+1)) u_sync_ques (
    .clock    (clock),
    .rst      (rst),
    .async_in ({auto_trig_timeout_pin, ques_cond_pin, detail_cond_pin}),
    .sync_out ({timeout_s, ques_cond_s, detail_cond_s})
  );

  ////////////////////////////////////////////////////////////////////////
  // Latched command and strobes to the register sets.
  reg  [1:0]       state;
  reg  [1:0]       next_state;
  reg  [3:0]       code;
  reg  [3:0]       sel;
  reg  [WIDTH-1:0] data;
  reg              preset_pulse;
  reg              psc_hold;
  // Clear status acts in its execute cycle; preset acts one edge later,
  // together with the filter and enable restore in every set.
  wire             exec = (state == ST_EXEC);
  wire             clear_all = rst | preset_pulse |
                               (exec && code == CMD_CLS);

  // Decodes a set-targeted strobe for register set index k.
  // A select that names no set produces no strobe at all.
  function strobe;
    input [3:0] want;
    input [3:0] have;
    input [3:0] which;
    input integer k;
    begin
      strobe = (want == have) && (which == k[3:0]);
    end
  endfunction

  // Flattened views of every set, set k at bits k*WIDTH.
  wire [NSETS*WIDTH-1:0] cond_all;
  wire [NSETS*WIDTH-1:0] event_all;
  wire [NSETS*WIDTH-1:0] read_all;
  wire [NSETS*WIDTH-1:0] rise_all;
  wire [NSETS*WIDTH-1:0] fall_all;
  wire [NSETS*WIDTH-1:0] en_all;
  wire [NSETS-1:0]       sum_all;
  wire [WIDTH-1:0]       ques_in;
  wire [DETAILS*WIDTH-1:0] detail_cond;

  // The integrity detail set carries the auto-trigger timeout at bit 10.
  // It is ORed in, so a detail pin wired to the same bit still reports.
  assign detail_cond = detail_cond_s |
    ({{(DETAILS*WIDTH-1){1'b0}}, timeout_s}
      << (`INTEGRITY_INDEX*WIDTH + `AUTO_TRIG_TIMEOUT_BIT));

  // Questionable bits not taken by a detail summary show the live pins.
  // Detail summaries occupy the low questionable bits; the integrity
  // detail sits on bit 9.
  function [WIDTH-1:0] place_details;
    input [DETAILS-1:0] s;
    input [WIDTH-1:0]   live;
    integer i;
    begin
      place_details = live;
      for (i = 0; i < DETAILS; i = i + 1)
        if (i == `INTEGRITY_INDEX)
          place_details[`INTEGRITY_SUM_BIT] = s[i];
        else
          place_details[i] = s[i];
    end
  endfunction

  assign ques_in = place_details(sum_all[DETAILS-1:0], ques_cond_s);

  ////////////////////////////////////////////////////////////////////////
  // Register sets: details 0..DETAILS-1, then operation, then top level.
  // cmd_set uses this same numbering. The operation set masks bit 15 in
  // condition, event and enable, so it can never reach the summary.
  genvar g;
  generate
    for (g = 0; g < NSETS; g = g + 1) begin : sets
      status_reg_set #(
        .WIDTH       (WIDTH),
        .ENABLE_INIT ((g == `INTEGRITY_INDEX) ? `INTEGRITY_ENABLE_RESET
                                               : `ENABLE_RESET),
        .UNUSED_MASK ((g == DETAILS) ? (16'h0001 << `OPER_UNUSED_BIT)
                                      : 16'h0000)
      ) u_set (
        .clock       (clock),
        .rst         (rst),
        .cond_in     ((g < DETAILS) ? detail_cond[g*WIDTH +: WIDTH] :
                      (g == DETAILS) ? oper_cond : ques_in),
        .wr_rise     (exec && strobe(code, CMD_WR_RISE, sel, g)),
        .wr_fall     (exec && strobe(code, CMD_WR_FALL, sel, g)),
        .wr_enable   (exec && strobe(code, CMD_WR_ENABLE, sel, g)),
        .wr_data     (data),
        .rd_event    (exec && strobe(code, CMD_RD_EVENT, sel, g)),
        .clear_all   (clear_all),
        .preset      (preset_pulse),
        .condition   (cond_all[g*WIDTH +: WIDTH]),
        .rise_filter (rise_all[g*WIDTH +: WIDTH]),
        .fall_filter (fall_all[g*WIDTH +: WIDTH]),
        .enable      (en_all[g*WIDTH +: WIDTH]),
        .event_bits  (event_all[g*WIDTH +: WIDTH]),
        .event_read  (read_all[g*WIDTH +: WIDTH]),
        .summary     (sum_all[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Status byte, master summary and request service.
  // A status byte read shows bit 6 as the master summary; the poll
  // answer puts the request bit there instead and clears it. Bit 6 of
  // the request enable is never stored, as the master summary would
  // otherwise feed itself.
  wire [7:0] stb_live;
  reg        prev_enabled;
  wire       enabled_any;

  // Live status byte: operation, master slot, standard event, data ready,
  // questionable, error queue, and two bits that always read zero.
  assign stb_live = {sum_all[DETAILS], 1'b0, std_event_summary,
                     output_data_ready, sum_all[DETAILS+1],
                     error_queue_not_empty, 2'b00};
  assign enabled_any = |(stb_live & srq_enable);
  assign master_summary_bit = enabled_any;

  // Only a fresh rise of an enabled summary raises a request; a
  // pending request is not re-armed until the poll reads it.
  always @(posedge clock) begin
    if (rst) begin
      status_byte         <= 8'h00;
      prev_enabled        <= 1'b0;
      request_service_bit <= 1'b0;
    end else begin
      status_byte  <= stb_live | ({7'h00, enabled_any}
                                  << `STB_MASTER_BIT);
      prev_enabled <= enabled_any;
      if (enabled_any && !prev_enabled)
        request_service_bit <= 1'b1;
      else if (exec && code == CMD_POLL)
        request_service_bit <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command sequencer: one command at a time, in order.
  // Walk: take in idle, act in execute, pass the answer state, then show
  // the valid pulse while already idle, so the next command may be taken
  // in the very cycle the answer is shown. A completion query parks in
  // its wait state and refuses every other command meanwhile.
  assign cmd_ready = (state == ST_IDLE);

  // Next state; only the idle state looks at cmd_valid.
  always @* begin
    case (state)
      ST_IDLE:     next_state = cmd_valid ? ST_EXEC : ST_IDLE;
      ST_EXEC:     next_state = (code == CMD_OPC_Q) ? ST_WAIT_OPC
                                                    : ST_ANSWER;
      ST_WAIT_OPC: next_state = ops_pending ? ST_WAIT_OPC
                                            : ST_ANSWER;
      ST_ANSWER:   next_state = ST_IDLE;
      default:     next_state = ST_IDLE;
    endcase
  end

  // Reads answer from the values sampled in the execute cycle.
  // Filter and enable writes therefore answer the value they replace, since the write
  // lands on the same edge that captures the answer.
  always @(posedge clock) begin
    if (rst) begin
      state             <= ST_IDLE;
      code              <= 4'h0;
      sel               <= 4'h0;
      data              <= {WIDTH{1'b0}};
      resp_valid        <= 1'b0;
      resp_data         <= {WIDTH{1'b0}};
      psc_hold          <= 1'b0;
      preset_pulse      <= 1'b0;
      clear_error_queue <= 1'b0;
    end else begin
      state             <= next_state;
      resp_valid        <= 1'b0;
      preset_pulse      <= 1'b0;
      clear_error_queue <= 1'b0;
      if (cmd_ready && cmd_valid) begin
        code <= cmd_code;
        sel  <= cmd_set;
        data <= cmd_data;
        psc_hold <= psc_value;
      end
      if (exec) begin
        case (code)
          CMD_RD_COND:  resp_data <= cond_all[sel*WIDTH +: WIDTH];
          CMD_RD_EVENT: resp_data <= event_all[sel*WIDTH +: WIDTH];
          CMD_WR_RISE:  resp_data <= rise_all[sel*WIDTH +: WIDTH];
          CMD_WR_FALL:  resp_data <= fall_all[sel*WIDTH +: WIDTH];
          CMD_WR_ENABLE: resp_data <= en_all[sel*WIDTH +: WIDTH];
          CMD_RD_STB:   resp_data <= {8'h00, status_byte};
          CMD_POLL:     resp_data <= {8'h00, status_byte[7],
                                      request_service_bit,
                                      status_byte[5:0]};
          CMD_CLS:      clear_error_queue <= 1'b1;
          CMD_PRESET:   preset_pulse <= 1'b1;
          default:      resp_data <= {WIDTH{1'b0}};
        endcase
      end
      // A select past the last set answers zero, not an unknown.
      if (exec && code <= CMD_WR_ENABLE && sel >= NSETS)
        resp_data <= {WIDTH{1'b0}};
      if (state == ST_WAIT_OPC && !ops_pending)
        resp_data <= {8'h00, `OPC_ANSWER};
      if (state == ST_ANSWER)
        resp_valid <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Common enables; kept across a plain reset unless cleared at power on.
  // The clear flag is a stored setting, so no reset ever changes it; it
  // and both enables are unknown until first written or cleared.
  always @(posedge clock) begin
    if (rst) begin
      if (power_on && power_on_clear) begin
        srq_enable <= `SRQ_ENABLE_RESET;
        std_enable <= `STD_ENABLE_RESET;
      end
    end else if (exec) begin
      if (code == CMD_WR_SRE)
        srq_enable <= data[7:0] & ~(8'h01 << `STB_MASTER_BIT);
      if (code == CMD_WR_ESE)
        std_enable <= data[7:0];
      if (code == CMD_WR_PSC)
        power_on_clear <= psc_hold;
    end
  end

endmodule // status_register_hierarchy

/* sim/status_hier_props.sv */
module status_hier_props (
  // Clock and reset.
  input logic       clock,
  input logic       rst,
  // Inputs that the checker relates outputs to.
  input logic       error_queue_not_empty,
  input logic       output_data_ready,
  input logic       ops_pending,
  input logic       cmd_valid,
  input logic [3:0] cmd_code,
  // Outputs under watch.
  input logic       cmd_ready,
  input logic       resp_valid,
  input logic [7:0] status_byte,
  input logic       master_summary_bit,
  input logic       request_service_bit,
  input logic       clear_error_queue
);
  // One clock domain, so a single default clock and disable serve all.
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////
  // Named steps of a command transfer.
  sequence s_take;
    cmd_valid && cmd_ready;
  endsequence
  sequence s_plain;
    s_take ##0 (cmd_code != 4'hA);
  endsequence
  sequence s_opc_wait;
    s_take ##0 (cmd_code == 4'hA) ##1 ops_pending[*3];
  endsequence

  ////////////////////////////////////////////////////////////////////////
  a_low_bits_zero: assert property (status_byte[1:0] == 2'b00)
    else $error("status byte low bits not zero");
  a_error_bit_follows: assert property (
    $rose(error_queue_not_empty) |-> ##[1:3] status_byte[2])
    else $error("error queue bit missing");
  a_ready_bit_follows: assert property (
    $rose(output_data_ready) |-> ##[1:3] status_byte[4])
    else $error("data ready bit missing");
  a_busy_refuses: assert property (s_take |=> (!cmd_ready)[*2])
    else $error("command taken while busy");
  a_answer_timing: assert property (
    s_plain |=> !resp_valid ##1 !resp_valid ##1 resp_valid)
    else $error("answer not three edges after take");
  a_answer_pulse: assert property (resp_valid |=> !resp_valid)
    else $error("answer strobe longer than one cycle");
  a_opc_holds: assert property (s_opc_wait |-> !resp_valid)
    else $error("completion answered while pending");
  a_clear_pulse: assert property (
    s_take ##0 (cmd_code == 4'h5) |-> ##[1:3] clear_error_queue)
    else $error("clear status did not empty queue");
  a_poll_clears: assert property (
    s_take ##0 (cmd_code == 4'h7) |-> ##[1:4] !request_service_bit)
    else $error("serial poll left request bit set");
  a_master_in_byte: assert property (
    $rose(master_summary_bit) |-> ##[0:2] status_byte[6])
    else $error("master summary absent from status byte");
endmodule // status_hier_props

bind status_register_hierarchy status_hier_props PROPS (
  .clock, .rst, .error_queue_not_empty, .output_data_ready, .ops_pending,
  .cmd_valid, .cmd_code, .cmd_ready, .resp_valid, .status_byte,
  .master_summary_bit, .request_service_bit, .clear_error_queue
);

/* sim/remote_ctrl.sv */
module remote_ctrl (
  // Clock.
  input  logic        clock,
  // Command request.
  output logic        cmd_valid,
  output logic [3:0]  cmd_code,
  output logic [3:0]  cmd_set,
  output logic [15:0] cmd_data,
  output logic        psc_value,
  // Handshake and answer.
  input  logic        cmd_ready,
  input  logic        resp_valid,
  input  logic [15:0] resp_data
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle at time zero, nothing requested.
  initial begin
    {cmd_valid, cmd_code, cmd_set, cmd_data, psc_value} = '0;
  end

  ////////////////////////////////////////////////////////////////////////
  // One command at a time: the next waits for the answer of this one.
  // A lost answer comes back unknown so the caller's compare fails.
  task send(input logic [3:0] code, input logic [3:0] set,
            input logic [15:0] data, output logic [15:0] rdata);
    int n;
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_code  <= code;
    cmd_set   <= set;
    cmd_data  <= data;
    psc_value <= data[0];
    n = 0;
    do @(posedge clock); while (!cmd_ready && ++n < 50);
    // Released code, set and data are scrambled; psc_value is left at the old value.
    cmd_valid <= 1'b0;
    cmd_code  <= ~code;
    cmd_set   <= ~set;
    cmd_data  <= ~data;
    n = 0;
    do @(posedge clock); while (!resp_valid && ++n < 1000);
    rdata = resp_valid ? resp_data : 16'hxxxx;
  endtask
endmodule // remote_ctrl

/* sim/status_register_hierarchy_test.sv */
module status_register_hierarchy_test;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clock, rst, power_on, auto_trig_timeout_pin;
  logic        error_queue_not_empty, output_data_ready;
  logic        std_event_summary, ops_pending, psc_value;
  logic        cmd_valid, cmd_ready, resp_valid, power_on_clear;
  logic        request_service_bit, master_summary_bit;
  logic        clear_error_queue;
  logic [3:0]  cmd_code, cmd_set;
  logic [15:0] oper_cond_pin, ques_cond_pin, cmd_data, resp_data, r;
  logic [95:0] detail_cond_pin;
  logic [7:0]  status_byte, srq_enable, std_enable;
  int          errors, total_checks;
  time         t0;

  status_register_hierarchy DUT (
    .clock, .rst, .power_on, .oper_cond_pin, .detail_cond_pin,
    .ques_cond_pin, .auto_trig_timeout_pin, .error_queue_not_empty,
    .output_data_ready, .std_event_summary, .ops_pending, .cmd_valid,
    .cmd_code, .cmd_set, .cmd_data, .psc_value, .cmd_ready, .resp_valid,
    .resp_data, .status_byte, .srq_enable, .std_enable, .power_on_clear,
    .request_service_bit, .master_summary_bit, .clear_error_queue
  );
  remote_ctrl CTRL (
    .clock, .cmd_valid, .cmd_code, .cmd_set, .cmd_data, .psc_value,
    .cmd_ready, .resp_valid, .resp_data
  );

  ////////////////////////////////////////////////////////////////////////
  // A 50 ns clock.
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Compare one result, with case equality so unknowns never match.
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Send one command and compare its answer.
  task ask(input logic [3:0] c, s, input logic [15:0] d, exp);
    CTRL.send(c, s, d, r);
    chk(r, exp);
  endtask

  task wait_n(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Reset pulse; conditions cross two sync flops, so allow settling.
  task pulse_reset(input logic with_power);
    rst      <= 1'b1;
    power_on <= with_power;
    wait_n(2);
    {rst, power_on} <= 2'b00;
    wait_n(1);
  endtask

  task conclude;
    $display("errors=%0d total_checks=%0d", errors, total_checks);
    if (errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // The run needs about 240 cycles; this cuts a hang short.
  initial begin
    wait_n(5000);
    errors++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    {rst, power_on, auto_trig_timeout_pin, ops_pending} = 4'b1000;
    {error_queue_not_empty, output_data_ready, std_event_summary} = '0;
    {oper_cond_pin, ques_cond_pin, detail_cond_pin} = '0;
    wait_n(16);
    rst <= 1'b0;
    wait_n(1);
    // Power-on clear flag, then a power-up and a plain reset.
    CTRL.send(4'hB, 4'h0, 16'h0001, r);
    chk({15'h0, power_on_clear}, 16'h0001);
    pulse_reset(1'b1);
    chk({srq_enable, std_enable}, 16'h0000);
    CTRL.send(4'h8, 4'h0, 16'h0048, r);
    CTRL.send(4'h9, 4'h0, 16'h0041, r);
    pulse_reset(1'b0);
    chk({std_enable, srq_enable}, 16'h4108);
    // Filter and enable defaults; writes keep exact bit weights.
    ask(4'h2, 4'h6, 16'h0041, 16'hFFFF);
    ask(4'h2, 4'h6, 16'hFFFF, 16'h0041);
    ask(4'h3, 4'h6, 16'h0000, 16'h0000);
    ask(4'h4, 4'h3, 16'hFFFF, 16'hFFFF);
    ask(4'h4, 4'h6, 16'h0041, 16'h0000);
    // Operation set: live mirror, sticky events, read clears.
    oper_cond_pin <= 16'h8041;
    wait_n(6);
    ask(4'h0, 4'h6, 16'h0000, 16'h0041);
    oper_cond_pin <= 16'h0000;
    wait_n(6);
    ask(4'h0, 4'h6, 16'h0000, 16'h0000);
    chk({8'h00, status_byte}, 16'h0080);
    ask(4'h1, 4'h6, 16'h0000, 16'h0041);
    ask(4'h1, 4'h6, 16'h0000, 16'h0000);
    wait_n(4);
    chk({8'h00, status_byte}, 16'h0000);
    // Both filters zero: no event either way.
    ask(4'h2, 4'h6, 16'h0000, 16'hFFFF);
    oper_cond_pin <= 16'h0001;
    wait_n(6);
    oper_cond_pin <= 16'h0000;
    wait_n(6);
    ask(4'h1, 4'h6, 16'h0000, 16'h0000);
    // Integrity set watches only clearings, on bits 0 to 14.
    ask(4'h2, 4'h3, 16'h0000, 16'hFFFF);
    ask(4'h3, 4'h3, 16'h7FFF, 16'h0000);
    ask(4'h4, 4'h7, 16'h0200, 16'h0000);
    auto_trig_timeout_pin <= 1'b1;
    {error_queue_not_empty, output_data_ready} <= 2'b11;
    wait_n(6);
    ask(4'h0, 4'h3, 16'h0000, 16'h0400);
    ask(4'h1, 4'h3, 16'h0000, 16'h0000);
    auto_trig_timeout_pin <= 1'b0;
    wait_n(8);
    chk({8'h00, status_byte}, 16'h005C);
    chk({15'h0, request_service_bit}, 16'h0001);
    ask(4'h6, 4'h0, 16'h0000, 16'h005C);
    ask(4'h7, 4'h0, 16'h0000, 16'h005C);
    chk({15'h0, request_service_bit}, 16'h0000);
    ask(4'h6, 4'h0, 16'h0000, 16'h005C);
    // Clear status drops the questionable path.
    CTRL.send(4'h5, 4'h0, 16'h0000, r);
    {error_queue_not_empty, std_event_summary} <= 2'b01;
    wait_n(4);
    chk({8'h00, status_byte}, 16'h0030);
    ask(4'h1, 4'h3, 16'h0000, 16'h0000);
    // Completion query is held off while work is pending.
    ops_pending <= 1'b1;
    t0 = $time;
    fork
      CTRL.send(4'hA, 4'h0, 16'h0000, r);
      begin
        wait_n(20);
        ops_pending <= 1'b0;
      end
    join
    chk(r, 16'h0001);
    chk({15'h0, ($time - t0) > 1000}, 16'h0001);
    // Preset restores both filters.
    CTRL.send(4'hC, 4'h0, 16'h0000, r);
    ask(4'h2, 4'h3, 16'hFFFF, 16'hFFFF);
    ask(4'h3, 4'h3, 16'h0000, 16'h0000);
    // A cleared power-on flag keeps both enables over a power-up.
    CTRL.send(4'hB, 4'h0, 16'h0000, r);
    chk({15'h0, power_on_clear}, 16'h0000);
    pulse_reset(1'b1);
    chk({std_enable, srq_enable}, 16'h4108);
    conclude();
  end
endmodule // status_register_hierarchy_test
